//--- src/dle_pkg.sv
// Package with register map, field positions, codes, counter limits and the reset value of the mode register.
package dle_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_STN_CNT  = 8'h08;
    localparam logic [7:0] OFS_STN_FLAG = 8'h0C;
    localparam logic [7:0] OFS_STN_RC   = 8'h10;
    localparam logic [7:0] OFS_BG_CNT   = 8'h14;
    localparam logic [7:0] OFS_SEL_CNT  = 8'h18;
    localparam logic [7:0] OFS_TSS_RC   = 8'h1C;
    localparam logic [7:0] OFS_THR      = 8'h20;

    // Station operating modes held in MODE[1:0].
    localparam logic [1:0] MODE_FDX_P2P = 2'h0;
    localparam logic [1:0] MODE_HDX_P2P = 2'h1;
    localparam logic [1:0] MODE_MP_CTRL = 2'h2;
    localparam logic [1:0] MODE_MP_TRIB = 2'h3;
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam int         MODE_IDX_LSB = 4;

    // Command bit: establish the tributary indexed in MODE.
    localparam int CMD_ESTABLISH = 0;

    // Link protocol states reported by the engine.
    localparam logic [1:0] PST_HALT = 2'h0;
    localparam logic [1:0] PST_START_INITIATE_STATE = 2'h1;
    localparam logic [1:0] PST_START_ACKNOWLEDGE_STATE = 2'h2;
    localparam logic [1:0] PST_RUN  = 2'h3;

    // Negative acknowledge reason codes.
    localparam logic [7:0] RSN_HBCC   = 8'h01;
    localparam logic [7:0] RSN_DBCC   = 8'h02;
    localparam logic [7:0] RSN_REP    = 8'h03;
    localparam logic [7:0] RSN_BUFTMP = 8'h08;
    localparam logic [7:0] RSN_OVRN   = 8'h09;
    localparam logic [7:0] RSN_BUFSML = 8'h10;
    localparam logic [7:0] RSN_HFMT   = 8'h11;

    // Station flag bit positions in STN_FLAG.
    localparam int FLG_REM_OVRN = 0;
    localparam int FLG_REM_HFMT = 1;
    localparam int FLG_SEL_ADDR = 2;
    localparam int FLG_STREAM   = 3;
    localparam int FLG_LOC_OVRN = 4;
    localparam int FLG_LOC_OVR  = 5;
    localparam int FLG_UNDR     = 6;
    localparam int FLG_LOC_HFMT = 7;
    localparam int FLG_W        = 8;

    // Counter widths and limits.
    localparam logic [2:0]  THR_MAX = 3'h7;
    localparam logic [7:0]  CNT8_MAX = 8'hFF;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;

    // Threshold counter indexes.
    localparam int THR_TX  = 0;
    localparam int THR_RX  = 1;
    localparam int THR_SEL = 2;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- src/dle_err_counters.sv
// Link error, traffic and threshold counters with an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - Selection timeouts are kept only in half-duplex point-to-point or multipoint control.
// - Timer expiry with no activity sets no-reply flag and counts a timeout.
// - Timer expiry after activity sets incomplete-reply flag and counts a timeout.
// - Carrier, sync sequence or SOH/ENQ/DLE received count as attempted transmission.
// - New data messages sent count in 16 bits, saturating; retransmissions excluded.
// - Good in-sequence data messages received count in 16 bits, saturating.
// - Select-flag messages sent count in 16 bits, only in selecting modes.
// - Station counters are 8-bit saturating, one set for the whole link.
// - Master clear or station read-and-clear empties all station counters.
// - Reason-nine NAK received or header format error counts a remote error.
// - Multipoint control counts address mismatch against selected tributary as remote error.
// - Babbling or streaming tributary counts a remote error with its flag.
// - Overrun counts local error; flag depends on whether reason-nine NAK goes out.
// - Transmit underrun or reason-17 NAK received counts a local error.
// - Global header check errors count in an 8-bit saturating counter.
// - Maintenance data field check errors count in an 8-bit saturating counter.
// - Threshold counters stop at 7 and then issue a notification.
// - In run the notified counter clears; in start states it stays at 7.
// - Transmit threshold rises on start messages, REP sent, or non-three NAK in run.
// - Transmit threshold clears on state entry, report, or acknowledgement in run.
// - Receive threshold rises when NAK reason 1,2,3,8,9 or 16 is sent.
// - Receive threshold clears on state entry, good message, or report in run.
// - Selection threshold rises on selection timeout, clears on select-bit message or report.
// - Per-tributary cumulative counters are 8-bit saturating, cleared by clear or establish.
module dle_err_counters import dle_pkg::*; #(
    parameter int NTRIB = 16
) (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Protocol engine state and tributary.
    input  wire logic [1:0]  proto_state,
    input  wire logic [3:0]  ev_trib,
    // Protocol engine events, one-cycle pulses except carrier, hdr_rx_active and the NAK reasons.
    input  wire logic        ev_data_tx,
    input  wire logic        ev_data_tx_retry,
    input  wire logic        ev_data_rx_ok,
    input  wire logic        ev_ctrl_rx_ok,
    input  wire logic        ev_select_tx,
    input  wire logic        ev_select_rx,
    input  wire logic        ev_select_expired,
    input  wire logic        ev_valid_hdr_rx,
    input  wire logic        carrier,
    input  wire logic        ev_sync_rx,
    input  wire logic        ev_lead_char_rx,
    input  wire logic        ev_nak_rx,
    input  wire logic [7:0]  nak_rx_reason,
    input  wire logic        ev_nak_tx,
    input  wire logic [7:0]  nak_tx_reason,
    input  wire logic        ev_hdr_format_rx,
    input  wire logic        ev_addr_mismatch,
    input  wire logic        ev_streaming,
    input  wire logic        ev_rx_overrun,
    input  wire logic        hdr_rx_active,
    input  wire logic        ev_tx_underrun,
    input  wire logic        ev_global_hbcc,
    input  wire logic        ev_maint_dbcc,
    input  wire logic        ev_start_tx,
    input  wire logic        ev_stack_tx,
    input  wire logic        ev_rep_tx,
    input  wire logic        ev_ack_new,
    // Threshold notification towards the control response path.
    output logic             thr_notify,
    output logic [2:0]       thr_notify_kind
);
    // Register and counter state.
    logic        aw_hold_q, w_hold_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [7:0]  mode_q;
    logic [7:0]  rem_cnt_q, loc_cnt_q, ghbcc_cnt_q, mdbcc_cnt_q;
    logic [FLG_W-1:0] stn_flag_q;
    logic [15:0] tx_cnt_q, rx_cnt_q, sel_int_q;
    logic [7:0]  sel_to_q [NTRIB];
    logic [1:0]  sel_flag_q;
    logic        activity_q;
    logic [2:0]  thr_q [3];
    logic        rep_q [3];
    logic [1:0]  pstate_q;

    function automatic logic [7:0] sat8(input logic [7:0] v, input logic inc, input logic clr);
        logic [7:0] base;
        base = clr ? 8'h00 : v;
        sat8 = (inc && base != CNT8_MAX) ? base + 8'h01 : base;
    endfunction

    function automatic logic [15:0] sat16(input logic [15:0] v, input logic inc,
                                          input logic clr);
        logic [15:0] base;
        base = clr ? 16'h0000 : v;
        sat16 = (inc && base != CNT16_MAX) ? base + 16'h0001 : base;
    endfunction

    function automatic logic [2:0] thr_next(input logic [2:0] v, input logic inc,
                                            input logic clr);
        thr_next = clr ? 3'h0 : ((inc && v != THR_MAX) ? v + 3'h1 : v);
    endfunction

    // Mode decode.
    wire logic [1:0] mode       = mode_q[1:0];
    wire logic [3:0] idx        = mode_q[MODE_IDX_LSB+3:MODE_IDX_LSB];
    wire logic       sel_mode   = (mode == MODE_HDX_P2P) || (mode == MODE_MP_CTRL);
    wire logic       in_run     = (proto_state == PST_RUN);
    wire logic       in_start   = (proto_state == PST_START_INITIATE_STATE) || (proto_state == PST_START_ACKNOWLEDGE_STATE);
    wire logic       state_entry = (proto_state != pstate_q) && (in_run || in_start);

    // Bus handshakes and decode.
    wire logic       wr_go  = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire logic       rd_go  = s_axi_arvalid && s_axi_arready;
    wire logic       wr_mode = wr_go && awaddr_q == OFS_MODE;
    wire logic       wr_cmd  = wr_go && awaddr_q == OFS_CMD;
    wire logic       wr_ok   = wr_mode || wr_cmd;
    wire logic       gss_clr = rd_go && s_axi_araddr == OFS_STN_RC;
    wire logic       tss_clr = rd_go && s_axi_araddr == OFS_TSS_RC;
    wire logic       estab   = wr_cmd && wstrb_q[0] && wdata_q[CMD_ESTABLISH];

    // Selection timeout classification.
    wire logic attempt  = carrier || ev_sync_rx || ev_lead_char_rx;
    wire logic activity = activity_q || attempt || ev_valid_hdr_rx || ev_ctrl_rx_ok;
    wire logic sel_tmo  = ev_select_expired && sel_mode;
    wire logic no_reply_to_select_flag_set = sel_tmo && !activity;
    wire logic incomplete_reply_flag_set = sel_tmo && activity;

    // Station event decode.
    wire logic rem_ovrn = ev_nak_rx && nak_rx_reason == RSN_OVRN;
    wire logic rem_hfmt = ev_hdr_format_rx;
    wire logic sel_addr = ev_addr_mismatch && mode == MODE_MP_CTRL;
    wire logic stream   = ev_streaming;
    wire logic ovr_nak  = ev_rx_overrun && in_run &&
                          !(mode == MODE_MP_TRIB && hdr_rx_active);
    wire logic ovr_none = ev_rx_overrun && !ovr_nak;
    wire logic loc_hfmt = ev_nak_rx && nak_rx_reason == RSN_HFMT;
    wire logic rem_ev   = rem_ovrn || rem_hfmt || sel_addr || stream;
    wire logic loc_ev   = ev_rx_overrun || ev_tx_underrun || loc_hfmt;
    wire logic [FLG_W-1:0] flag_set = {loc_hfmt, ev_tx_underrun, ovr_none, ovr_nak,
                                       stream, sel_addr, rem_hfmt, rem_ovrn};

    // Threshold event decode.
    wire logic nak_tx_thr = ev_nak_tx && (nak_tx_reason == RSN_HBCC ||
        nak_tx_reason == RSN_DBCC || nak_tx_reason == RSN_REP ||
        nak_tx_reason == RSN_BUFTMP || nak_tx_reason == RSN_OVRN ||
        nak_tx_reason == RSN_BUFSML);
    wire logic tx_inc = (proto_state == PST_START_INITIATE_STATE && ev_start_tx) ||
                        (proto_state == PST_START_ACKNOWLEDGE_STATE && ev_stack_tx) ||
                        (in_run && (ev_rep_tx ||
                        (ev_nak_rx && nak_rx_reason != RSN_REP)));
    wire logic [2:0] thr_inc = {sel_tmo, nak_tx_thr, tx_inc};
    wire logic [2:0] notify  = {thr_q[THR_SEL] == THR_MAX && !rep_q[THR_SEL],
                                thr_q[THR_RX] == THR_MAX && !rep_q[THR_RX],
                                thr_q[THR_TX] == THR_MAX && !rep_q[THR_TX]};
    wire logic [2:0] run_clr = in_run ? notify : 3'h0;
    wire logic [2:0] thr_clr = run_clr | {ev_select_rx,
        state_entry || ev_ctrl_rx_ok || ev_data_rx_ok,
        state_entry || (in_run && ev_ack_new)};

    // Read data selection.
    wire logic [31:0] stn_word = {mdbcc_cnt_q, ghbcc_cnt_q, loc_cnt_q, rem_cnt_q};
    wire logic [31:0] sel_word = {6'h00, sel_flag_q, sel_to_q[idx], sel_int_q};
    wire logic [31:0] thr_word = {13'h0000, thr_notify_kind, 5'h00, thr_q[THR_SEL],
                                  1'b0, thr_q[THR_RX], 1'b0, thr_q[THR_TX]};
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_MODE:               rd_word = {24'h000000, mode_q};
            OFS_STN_CNT, OFS_STN_RC: rd_word = stn_word;
            OFS_STN_FLAG:           rd_word = {{(32-FLG_W){1'b0}}, stn_flag_q};
            OFS_BG_CNT:             rd_word = {rx_cnt_q, tx_cnt_q};
            OFS_SEL_CNT, OFS_TSS_RC: rd_word = sel_word;
            OFS_THR:                rd_word = thr_word;
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write address and data are taken independently and held until the response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !wr_go;
            s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !wr_go;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write response and read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Mode register and protocol state tracker.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q   <= MODE_RESET;
            pstate_q <= PST_HALT;
        end else begin
            pstate_q <= proto_state;
            if (wr_mode && wstrb_q[0]) begin
                mode_q <= wdata_q[7:0];
            end
        end
    end

    // Station counters and flags, one set for the link.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rem_cnt_q   <= 8'h00;
            loc_cnt_q   <= 8'h00;
            ghbcc_cnt_q <= 8'h00;
            mdbcc_cnt_q <= 8'h00;
            stn_flag_q  <= '0;
        end else begin
            rem_cnt_q   <= sat8(rem_cnt_q, rem_ev, gss_clr);
            loc_cnt_q   <= sat8(loc_cnt_q, loc_ev, gss_clr);
            ghbcc_cnt_q <= sat8(ghbcc_cnt_q, ev_global_hbcc, gss_clr);
            mdbcc_cnt_q <= sat8(mdbcc_cnt_q, ev_maint_dbcc, gss_clr);
            stn_flag_q  <= (gss_clr ? '0 : stn_flag_q) | flag_set;
        end
    end

    // Background traffic counters and selection state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_cnt_q   <= 16'h0000;
            rx_cnt_q   <= 16'h0000;
            sel_int_q  <= 16'h0000;
            sel_flag_q <= 2'h0;
            activity_q <= 1'b0;
        end else begin
            tx_cnt_q  <= sat16(tx_cnt_q, ev_data_tx && !ev_data_tx_retry, tss_clr);
            rx_cnt_q  <= sat16(rx_cnt_q, ev_data_rx_ok, tss_clr);
            sel_int_q <= sat16(sel_int_q, ev_select_tx && sel_mode, tss_clr);
            sel_flag_q <= (tss_clr ? 2'h0 : sel_flag_q) | {incomplete_reply_flag_set, no_reply_to_select_flag_set};
            if (ev_select_expired || ev_select_tx) begin
                activity_q <= 1'b0;
            end else if (activity) begin
                activity_q <= 1'b1;
            end
        end
    end

    // Cumulative selection timeout counter for each tributary.
    for (genvar t = 0; t < NTRIB; t++) begin : g_trib
        wire logic clr_t = (tss_clr || estab) && idx == 4'(t);
        wire logic inc_t = sel_tmo && ev_trib == 4'(t);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sel_to_q[t] <= 8'h00;
            end else begin
                sel_to_q[t] <= sat8(sel_to_q[t], inc_t, clr_t);
            end
        end
    end

    // Threshold counters and notification.
    for (genvar k = 0; k < 3; k++) begin : g_thr
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                thr_q[k] <= 3'h0;
                rep_q[k] <= 1'b0;
            end else begin
                thr_q[k] <= thr_next(thr_q[k], thr_inc[k], thr_clr[k]);
                rep_q[k] <= notify[k] ? !in_run : (rep_q[k] && thr_q[k] == THR_MAX);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thr_notify      <= 1'b0;
            thr_notify_kind <= 3'h0;
        end else begin
            thr_notify <= |notify;
            if (|notify) begin
                thr_notify_kind <= notify;
            end
        end
    end

    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tx_count_sat_a: assert property ((ev_data_tx && !ev_data_tx_retry && !tss_clr
        && tx_cnt_q != CNT16_MAX) |=> tx_cnt_q == $past(tx_cnt_q) + 16'h0001)
        else $error("data transmit count did not advance");
    retry_skip_a: assert property ((ev_data_tx_retry && !tss_clr) |=> $stable(tx_cnt_q))
        else $error("retransmission was counted");
    rx_hold_a: assert property ((rx_cnt_q == CNT16_MAX && !tss_clr) |=> rx_cnt_q == CNT16_MAX)
        else $error("receive count left saturation");
    sel_gate_a: assert property ((!sel_mode && !tss_clr) |=> $stable(sel_int_q))
        else $error("selection intervals counted outside selecting mode");
    gss_clear_a: assert property ((gss_clr && !rem_ev) |=> rem_cnt_q == 8'h00)
        else $error("station counter not cleared");
    clear_keep_a: assert property ((gss_clr && loc_ev) |=> loc_cnt_q == 8'h01)
        else $error("event lost during clear");
    no_reply_to_select_flag_flag_a: assert property (no_reply_to_select_flag_set |=> sel_flag_q[0])
        else $error("no-reply flag missing");
    incomplete_reply_flag_flag_a: assert property ((sel_mode && ev_select_expired && carrier) |=> sel_flag_q[1])
        else $error("incomplete-reply flag missing");
    ovr_route_a: assert property ((ev_rx_overrun && !in_run && !gss_clr)
        |=> stn_flag_q[FLG_LOC_OVR])
        else $error("overrun outside run not flagged");
    thr_cap_a: assert property (thr_q[THR_RX] == THR_MAX && !thr_clr[THR_RX]
        |=> thr_q[THR_RX] == THR_MAX)
        else $error("threshold passed its limit");
    run_notify_a: assert property ((in_run && thr_q[THR_RX] == THR_MAX && !rep_q[THR_RX])
        |=> thr_notify ##0 thr_q[THR_RX] <= 3'h1)
        else $error("run notification did not clear counter");
    start_keep_a: assert property ((in_start && notify[THR_TX] && !thr_clr[THR_TX])
        |=> thr_q[THR_TX] == THR_MAX ##1 !notify[THR_TX] || thr_clr[THR_TX])
        else $error("start state counter not held");
    sel_thr_a: assert property ((sel_tmo && !thr_clr[THR_SEL] && thr_q[THR_SEL] < THR_MAX)
        |=> thr_q[THR_SEL] == $past(thr_q[THR_SEL]) + 3'h1)
        else $error("selection threshold did not rise");
    rd_answer_a: assert property (rd_go |=> s_axi_rvalid && s_axi_rdata == $past(rd_word))
        else $error("read did not return the pre-clear value");

    notify_c: cover property (thr_notify);
    gss_race_c: cover property (gss_clr && rem_ev);
    incomplete_reply_flag_c: cover property (incomplete_reply_flag_set);
    wr_ok_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_OKAY);
endmodule

//--- bench/dle_proto_model.sv
// Protocol engine model: bench requests become one-cycle event pulses.
`timescale 1ns/1ps
module dle_proto_model (
    // Clock and bench requests.
    input  wire logic        aclk,
    input  wire logic [22:0] ev_req,
    input  wire logic [7:0]  rsn_req,
    // Event pulses and NAK reason.
    output logic      [22:0] ev,
    output logic      [7:0]  rsn
);
    // Between pulses the reason shows the inverse so a stale code never passes.
    always_ff @(posedge aclk) begin
        ev  <= ev_req;
        rsn <= (ev_req != 23'h0) ? rsn_req : ~rsn_req;
    end
endmodule

//--- bench/testbench.sv
// Bench for the link error counters, driven over the register bus.
`timescale 1ns/1ps
module testbench import dle_pkg::*;;
    typedef struct packed {
        logic [1:0]  mode;
        logic [22:0] ev;
        logic [7:0]  rsn;
        logic [7:0]  ofs;
        logic [31:0] want;
    } dle_row_t;
    dle_row_t    rows [20] = '{
        '{2'h0, 23'h400, 8'h09, 8'h0C, 32'h1}, '{2'h0, 23'h1000, 8'h00, 8'h0C, 32'h2},
        '{2'h2, 23'h2000, 8'h00, 8'h0C, 32'h4}, '{2'h0, 23'h2000, 8'h00, 8'h08, 32'h0},
        '{2'h0, 23'h4000, 8'h00, 8'h0C, 32'h8}, '{2'h0, 23'h8000, 8'h00, 8'h0C, 32'h10},
        '{2'h0, 23'h10000, 8'h00, 8'h08, 32'h100}, '{2'h0, 23'h400, 8'h11, 8'h0C, 32'h80},
        '{2'h0, 23'h20000, 8'h00, 8'h08, 32'h10000}, '{2'h0, 23'h40000, 8'h00, 8'h08, 32'h1000000},
        '{2'h0, 23'h1, 8'h00, 8'h14, 32'h1}, '{2'h0, 23'h3, 8'h00, 8'h14, 32'h0},
        '{2'h0, 23'h4, 8'h00, 8'h14, 32'h10000}, '{2'h1, 23'h10, 8'h00, 8'h18, 32'h1},
        '{2'h0, 23'h10, 8'h00, 8'h18, 32'h0}, '{2'h1, 23'h40, 8'h00, 8'h18, 32'h1010000},
        '{2'h1, 23'h140, 8'h00, 8'h18, 32'h2010000}, '{2'h1, 23'h240, 8'h00, 8'h18, 32'h2010000},
        '{2'h1, 23'hC0, 8'h00, 8'h18, 32'h2010000}, '{2'h0, 23'h40, 8'h00, 8'h18, 32'h0}};
    logic [7:0]  rsn_tab [7] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h10, 8'h01};
    logic        aclk = 1'b0, aresetn = 1'b0, thr_notify, carrier = 1'b0, hdr_rx_active = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rsn_req = 8'h00, rsn;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, proto_state = 2'h3;
    logic [2:0]  thr_notify_kind;
    logic [22:0] ev_req = 23'h0, ev;
    int          fails = 0, samples_checked = 0;
    dle_proto_model u_dle_proto_model (.aclk(aclk), .ev_req(ev_req), .rsn_req(rsn_req),
                                       .ev(ev), .rsn(rsn));
    dle_err_counters u_dle_err_counters (.*, .s_axi_wstrb(4'hF), .ev_trib(4'h0),
        .carrier(carrier), .hdr_rx_active(hdr_rx_active), .nak_rx_reason(rsn),
        .nak_tx_reason(rsn),
        .ev_data_tx(ev[0]), .ev_data_tx_retry(ev[1]), .ev_data_rx_ok(ev[2]),
        .ev_ctrl_rx_ok(ev[3]), .ev_select_tx(ev[4]), .ev_select_rx(ev[5]),
        .ev_select_expired(ev[6]), .ev_valid_hdr_rx(ev[7]), .ev_sync_rx(ev[8]),
        .ev_lead_char_rx(ev[9]), .ev_nak_rx(ev[10]), .ev_nak_tx(ev[11]),
        .ev_hdr_format_rx(ev[12]), .ev_addr_mismatch(ev[13]), .ev_streaming(ev[14]),
        .ev_rx_overrun(ev[15]), .ev_tx_underrun(ev[16]), .ev_global_hbcc(ev[17]),
        .ev_maint_dbcc(ev[18]), .ev_start_tx(ev[19]), .ev_stack_tx(ev[20]),
        .ev_rep_tx(ev[21]), .ev_ack_new(ev[22]));
    always #50 aclk = ~aclk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        got = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pulse(input logic [22:0] m, input logic [7:0] r);
        ev_req  <= m;
        rsn_req <= r;
        @(posedge aclk);
        ev_req <= 23'h0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] w);
        samples_checked++;
        if (g !== w) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, w);
        end
    endtask
    // The notification lasts one cycle, so it is looked for just after each edge.
    task automatic notify_chk(input logic [2:0] k);
        int n;
        n = 0;
        #1;
        while (thr_notify !== 1'b1 && n < 10) begin
            @(posedge aclk);
            #1;
            n++;
        end
        chk({28'h0, thr_notify_kind, thr_notify}, {28'h0, k, 1'b1});
        @(posedge aclk);
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_STN_CNT);
        chk(got, 32'h0);
        rd(8'h24);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(OFS_STN_CNT, 32'hFF);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        foreach (rows[i]) begin
            wr(OFS_MODE, {30'h0, rows[i].mode});
            pulse(rows[i].ev, rows[i].rsn);
            rd(rows[i].ofs);
            chk(got, rows[i].want);
            rd(OFS_STN_RC);
            rd(OFS_TSS_RC);
        end
        wr(OFS_MODE, 32'h3);
        hdr_rx_active <= 1'b1;
        pulse(23'h8000, 8'h00);
        hdr_rx_active <= 1'b0;
        rd(OFS_STN_FLAG);
        chk(got, 32'h20);
        // The underrun reaches the counters at the edge that takes the clearing read.
        ev_req <= 23'h10000;
        @(posedge aclk);
        ev_req <= 23'h0;
        rd(OFS_STN_RC);
        chk(got, 32'h100);
        rd(OFS_STN_CNT);
        chk(got, 32'h100);
        proto_state <= PST_HALT;
        pulse(23'h8000, 8'h00);
        rd(OFS_STN_FLAG);
        chk(got, 32'h60);
        proto_state <= PST_START_INITIATE_STATE;
        @(posedge aclk);
        proto_state <= PST_RUN;
        rd(OFS_THR);
        chk(got, 32'h400);
        wr(OFS_MODE, 32'h1);
        carrier <= 1'b1;
        pulse(23'h40, 8'h00);
        carrier <= 1'b0;
        rd(OFS_SEL_CNT);
        chk(got, 32'h2010000);
        wr(OFS_CMD, 32'h1);
        rd(OFS_SEL_CNT);
        chk(got, 32'h2000000);
        pulse(23'h20, 8'h00);
        foreach (rsn_tab[i]) pulse(23'h800, rsn_tab[i]);
        notify_chk(3'h2);
        rd(OFS_THR);
        chk(got, 32'h20000);
        proto_state <= PST_START_INITIATE_STATE;
        repeat (7) pulse(23'h80000, 8'h00);
        notify_chk(3'h1);
        rd(OFS_THR);
        chk(got, 32'h10007);
        proto_state <= PST_RUN;
        @(posedge aclk);
        rd(OFS_THR);
        chk(got, 32'h10000);
        pulse(23'h200000, 8'h00);
        rd(OFS_THR);
        chk(got, 32'h10001);
        pulse(23'h400000, 8'h00);
        rd(OFS_THR);
        chk(got, 32'h10000);
        complete_run;
    end
endmodule
